// File: src/ace_clmul.sv
`timescale 1ns/1ps

// Carry-less 32x32 multiply, purely combinational.
module ace_clmul
    import ace_pkg::*;
#(
    parameter int W = ACE_DATA_W
) (
    // Operands.
    input  wire logic [W-1:0]   i_a,
    input  wire logic [W-1:0]   i_b,
    // Product.
    output logic      [2*W-1:0] o_p
);

    // =========================================================
    // Partial products
    // =========================================================
    logic [2*W-1:0] part [W+1];

    assign part[0] = '0;

    // Each set bit of b contributes a shifted copy of a; XOR replaces add.
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_pp
            assign part[g+1] = part[g] ^ (i_b[g] ? ({{W{1'b0}}, i_a} << g) : '0);
        end
    endgenerate

    assign o_p = part[W];

endmodule

// File: src/ace_pkg.sv
package ace_pkg;

    // Operation codes presented by the decoder with a one-cycle request strobe.
    typedef enum logic [3:0] {
        ACE_OP_NONE, ACE_OP_UMUL, ACE_OP_UMAC, ACE_OP_SMUL, ACE_OP_SMAC,
        ACE_OP_SDIV, ACE_OP_UDIV, ACE_OP_SHR_OUT, ACE_OP_SHL_IN, ACE_OP_PMAC,
        ACE_OP_PMUL, ACE_OP_SHUF, ACE_OP_ROT_IMM, ACE_OP_ROT_VAR
    } ace_op_t;

    localparam int ACE_DATA_W    = 32;
    localparam int ACE_EXT_W     = 8;
    localparam int ACE_EXT_MIN   = 8;
    localparam int ACE_SHUF_N    = 6;
    localparam int ACE_IDX_W     = 5;
    localparam int ACE_ROT_W     = 5;

endpackage

// File: src/ace_top.sv
`timescale 1ns/1ps

// Accumulator extension for the multiply/divide unit plus rotates.
module ace_top
    import ace_pkg::*;
#(
    parameter int EXT_W = ACE_EXT_W
) (
    // Clock and reset.
    input  wire logic                  i_clk,
    input  wire logic                  i_resetn,
    // Request from decode.
    input  wire logic                  i_valid,
    input  wire ace_op_t               i_op,
    input  wire logic [ACE_DATA_W-1:0] i_rs,
    input  wire logic [ACE_DATA_W-1:0] i_rt,
    input  wire logic [ACE_ROT_W-1:0]  i_shamt,
    // Results for decode and the register file.
    output logic                       o_rd_valid,
    output logic      [ACE_DATA_W-1:0] o_rd_data,
    output logic      [ACE_DATA_W-1:0] o_hi,
    output logic      [ACE_DATA_W-1:0] o_lo,
    output logic      [EXT_W-1:0]      o_ext
);

    localparam int DW = ACE_DATA_W;

    // =========================================================
    // Elaboration check
    // =========================================================
    // Extension width is bounded on a 32-bit core.
    if (EXT_W < ACE_EXT_MIN || EXT_W > DW) begin : g_bad_ext
        $error("Extension width must lie within 8 to 32 bits.");
    end

    // =========================================================
    // Accumulator state
    // =========================================================
    logic [EXT_W-1:0] ext;
    logic [DW-1:0]    hi;
    logic [DW-1:0]    lo;
    logic [EXT_W-1:0] next_ext;
    logic [DW-1:0]    next_hi;
    logic [DW-1:0]    next_lo;
    logic             next_rd_valid;
    logic [DW-1:0]    next_rd_data;

    // =========================================================
    // Datapaths
    // =========================================================
    logic [2*DW-1:0]       poly;
    logic [2*DW-1:0]       uprod;
    logic signed [2*DW-1:0] sprod;
    logic [EXT_W+2*DW-1:0] acc_cat;
    logic [EXT_W+2*DW-1:0] usum;
    logic [EXT_W+2*DW-1:0] ssum;
    logic [EXT_W+2*DW-1:0] shuf_shift;
    logic [ACE_SHUF_N-1:0] shuf_bits;
    logic [DW-1:0]         quot;
    logic [DW-1:0]         rem;
    logic [DW-1:0]         squot;
    logic [DW-1:0]         srem;
    logic [ACE_ROT_W-1:0]  rot_imm;
    logic [ACE_ROT_W-1:0]  rot_var;
    logic [DW-1:0]         rot_imm_res;
    logic [DW-1:0]         rot_var_res;

    ace_clmul #(.W(DW)) u_clmul (
        .i_a (i_rs),
        .i_b (i_rt),
        .o_p (poly)
    );

    assign acc_cat = {ext, hi, lo};
    assign uprod   = {{DW{1'b0}}, i_rs} * {{DW{1'b0}}, i_rt};
    assign sprod   = $signed({{DW{i_rs[DW-1]}}, i_rs}) * $signed({{DW{i_rt[DW-1]}}, i_rt});
    // Unsigned accumulate keeps the carry out of the upper word.
    assign usum    = acc_cat + {{EXT_W{1'b0}}, uprod};
    // Signed accumulate is sign-extended over the full width, so overflow reaches the extension.
    assign ssum    = acc_cat + {{EXT_W{sprod[2*DW-1]}}, sprod};
    // Shuffle moves the whole accumulator up six bit places.
    assign shuf_shift = acc_cat << ACE_SHUF_N;

    // Each shuffle bit picks one input bit by a five-bit index in rt.
    genvar s;
    generate
        for (s = 0; s < ACE_SHUF_N; s++) begin : g_shuf
            assign shuf_bits[s] = i_rs[i_rt[s*ACE_IDX_W +: ACE_IDX_W]];
        end
    endgenerate

    // Divide by zero returns all ones quotient and the dividend, avoiding X.
    assign quot  = (i_rt == '0) ? '1 : i_rs / i_rt;
    assign rem   = (i_rt == '0) ? i_rs : i_rs % i_rt;
    assign squot = (i_rt == '0) ? '1 : DW'($signed(i_rs) / $signed(i_rt));
    assign srem  = (i_rt == '0) ? i_rs : DW'($signed(i_rs) % $signed(i_rt));

    // Rotates; the variable count uses only its five low bits.
    assign rot_imm     = i_shamt;
    assign rot_var     = i_rt[ACE_ROT_W-1:0];
    assign rot_imm_res = (i_rs >> rot_imm) | (i_rs << (6'd32 - {1'b0, rot_imm}));
    assign rot_var_res = (i_rs >> rot_var) | (i_rs << (6'd32 - {1'b0, rot_var}));

    // =========================================================
    // Next-state selection
    // =========================================================
    always_comb begin
        next_ext      = ext;
        next_hi       = hi;
        next_lo       = lo;
        next_rd_valid = 1'b0;
        next_rd_data  = o_rd_data;
        if (i_valid) begin
            case (i_op)
                ACE_OP_UMUL: begin
                    next_ext = '0;
                    {next_hi, next_lo} = uprod;
                end
                ACE_OP_UMAC: begin
                    {next_ext, next_hi, next_lo} = usum;
                end
                ACE_OP_SMUL: begin
                    next_ext = '0;
                    {next_hi, next_lo} = sprod;
                end
                ACE_OP_SMAC: begin
                    {next_ext, next_hi, next_lo} = ssum;
                end
                ACE_OP_SDIV: begin
                    next_ext = '0;
                    next_lo  = squot;
                    next_hi  = srem;
                end
                ACE_OP_UDIV: begin
                    next_ext = '0;
                    next_lo  = quot;
                    next_hi  = rem;
                end
                ACE_OP_SHR_OUT: begin
                    next_rd_valid = 1'b1;
                    next_rd_data  = lo;
                    next_lo       = hi;
                    next_hi       = DW'(ext);
                    next_ext      = '0;
                end
                ACE_OP_SHL_IN: begin
                    next_ext = hi[EXT_W-1:0];
                    next_hi  = lo;
                    next_lo  = i_rs;
                end
                ACE_OP_PMAC: begin
                    // Extension is neither read nor written here.
                    {next_hi, next_lo} = {hi, lo} ^ poly;
                end
                ACE_OP_PMUL: begin
                    {next_hi, next_lo} = poly;
                end
                ACE_OP_SHUF: begin
                    {next_ext, next_hi, next_lo} =
                        {shuf_shift[EXT_W+2*DW-1:ACE_SHUF_N], shuf_bits};
                end
                ACE_OP_ROT_IMM: begin
                    next_rd_valid = 1'b1;
                    next_rd_data  = rot_imm_res;
                end
                ACE_OP_ROT_VAR: begin
                    next_rd_valid = 1'b1;
                    next_rd_data  = rot_var_res;
                end
                default: begin
                    next_rd_valid = 1'b0;
                end
            endcase
        end
    end

    // =========================================================
    // State registers
    // =========================================================
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ext        <= '0;
            hi         <= '0;
            lo         <= '0;
            o_rd_valid <= 1'b0;
            o_rd_data  <= '0;
        end else begin
            ext        <= next_ext;
            hi         <= next_hi;
            lo         <= next_lo;
            o_rd_valid <= next_rd_valid;
            o_rd_data  <= next_rd_data;
        end
    end

    assign o_ext = ext;
    assign o_hi  = hi;
    assign o_lo  = lo;

    // =========================================================
    // Checks
    // =========================================================
    a_umul_clears: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_op == ACE_OP_UMUL |=> ext == '0 && {hi, lo} == $past(uprod))
        else $error("Unsigned product did not clear extension.");
    a_out_shift: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_op == ACE_OP_SHR_OUT |=> o_rd_valid && o_rd_data == $past(lo)
        && lo == $past(hi) && hi == DW'($past(ext)))
        else $error("Move-out shift wrong.");
    a_in_shift: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_op == ACE_OP_SHL_IN |=> ext == $past(hi[EXT_W-1:0])
        && hi == $past(lo) && lo == $past(i_rs))
        else $error("Move-in shift wrong.");
    a_pmac_keep: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_op == ACE_OP_PMAC |=> $stable(ext))
        else $error("Poly accumulate changed extension.");
    a_pmac_xor: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_op == ACE_OP_PMAC |=> {hi, lo} == ($past({hi, lo}) ^ $past(poly)))
        else $error("Poly accumulate result wrong.");
    a_pmul_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_op == ACE_OP_PMUL |=> {hi, lo} == $past(poly))
        else $error("Poly product wrong.");
    a_out_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_op == ACE_OP_SHR_OUT |=> ext == '0)
        else $error("Move-out did not clear extension.");
    a_shuf_shift: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_op == ACE_OP_SHUF |=>
        ({ext, hi, lo} >> ACE_SHUF_N)
        == ($past(acc_cat) & ({(EXT_W+2*DW){1'b1}} >> ACE_SHUF_N)))
        else $error("Shuffle shift wrong.");
    a_umac_carry: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_op == ACE_OP_UMAC |=> {ext, hi, lo} == $past(usum))
        else $error("Unsigned accumulate wrong.");
    a_rotv_count: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_valid && i_op == ACE_OP_ROT_VAR |=>
        o_rd_data == (($past(i_rs) >> $past(i_rt[4:0])) | ($past(i_rs) << (6'd32 - $past(i_rt[4:0])))))
        else $error("Variable rotate wrong.");

endmodule

// File: test/ace_core_model.sv
`timescale 1ns/1ps

// ====================================================================
// Decode side: issues one operation a cycle and keeps the write-back.
module ace_core_model
    import ace_pkg::*;
(
    // Clock.
    input  wire logic                  i_clk,
    // Results from the block.
    input  wire logic                  i_rd_valid,
    input  wire logic [ACE_DATA_W-1:0] i_rd_data,
    // Request to the block.
    output logic                       o_valid,
    output ace_op_t                    o_op,
    output logic      [ACE_DATA_W-1:0] o_rs,
    output logic      [ACE_DATA_W-1:0] o_rt,
    output logic      [ACE_ROT_W-1:0]  o_shamt,
    // Last value written to a destination register.
    output logic      [ACE_DATA_W-1:0] o_wb
);
    // Quiet request lines at time zero.
    initial begin
        o_valid = 1'b0;
        o_op    = ACE_OP_NONE;
        o_rs    = 32'h0;
        o_rt    = 32'h0;
        o_shamt = 5'h00;
        o_wb    = 32'h0;
    end

    // Present one request just after a falling edge and hold it one cycle.
    task automatic issue(input ace_op_t op, input logic [31:0] rs, input logic [31:0] rt,
                         input logic [4:0] sh, input logic vld);
        o_valid = vld;
        o_op    = op;
        o_rs    = rs;
        o_rt    = rt;
        o_shamt = sh;
        @(negedge i_clk);
    endtask

    // Released operands are inverted so a stale value is never mistaken for a live one.
    task automatic idle();
        o_valid = 1'b0;
        o_rs    = ~o_rs;
        o_rt    = ~o_rt;
        @(negedge i_clk);
    endtask

    // Register file write port.
    always @(posedge i_clk) begin
        if (i_rd_valid === 1'b1) begin
            o_wb <= i_rd_data;
        end
    end
endmodule

// File: test/test_accumulator_crypto_extension.sv
`timescale 1ns/1ps

module test_accumulator_crypto_extension
    import ace_pkg::*;
();
    localparam int EW = 8;
    typedef struct packed {
        ace_op_t     op;
        logic [31:0] rs;
        logic [31:0] rt;
        logic [4:0]  sh;
    } ace_row_t;
    localparam int ROWS = 20;
    // Ordinary cases, back to back; each row sees the state that the one before left.
    localparam ace_row_t rows [ROWS] = '{
        '{ACE_OP_SHL_IN, 32'ha5a50001, 32'h0, 5'h00}, '{ACE_OP_SHL_IN, 32'h12345678, 32'h0, 5'h00},
        '{ACE_OP_SHL_IN, 32'hdeadbeef, 32'h0, 5'h00}, '{ACE_OP_UMAC, 32'hffffffff, 32'hffffffff, 5'h00},
        '{ACE_OP_UMAC, 32'hffffffff, 32'hffffffff, 5'h00}, '{ACE_OP_SHR_OUT, 32'h0, 32'h0, 5'h00},
        '{ACE_OP_UMAC, 32'h80000000, 32'hffffffff, 5'h00}, '{ACE_OP_UMUL, 32'hffffffff, 32'h3, 5'h00},
        '{ACE_OP_PMUL, 32'h8000000f, 32'h80000003, 5'h00}, '{ACE_OP_SHL_IN, 32'h0000ffff, 32'h0, 5'h00},
        '{ACE_OP_PMAC, 32'hf0f0f0f0, 32'h0f0f0f0f, 5'h00}, '{ACE_OP_SHUF, 32'h13579bdf, 32'h0be8841f, 5'h00},
        '{ACE_OP_SHR_OUT, 32'h0, 32'h0, 5'h00}, '{ACE_OP_ROT_IMM, 32'h80000001, 32'h0, 5'h00},
        '{ACE_OP_ROT_IMM, 32'h80000001, 32'h0, 5'h1f}, '{ACE_OP_ROT_VAR, 32'h12345678, 32'hffffffe4, 5'h00},
        '{ACE_OP_SMUL, 32'hfffffffe, 32'h3, 5'h00}, '{ACE_OP_SMAC, 32'h7fffffff, 32'h7fffffff, 5'h00},
        '{ACE_OP_SDIV, 32'hfffffff9, 32'h2, 5'h00}, '{ACE_OP_UDIV, 32'h7, 32'h0, 5'h00}};

    logic          clk = 1'b0;
    logic          resetn = 1'b0;
    logic          valid;
    ace_op_t       op;
    logic [31:0]   rs, rt, rd_data, hi, lo, wb, e_hi, e_lo, e_rd;
    logic [4:0]    shamt;
    logic          rd_valid, e_rdv;
    logic [EW-1:0] ext, e_ext;
    int            failures = 0;
    int            total_checks = 0;

    // ================================================================
    // Clock, block and decode model.
    always #12.5 clk = ~clk;
    ace_top #(.EXT_W(EW)) uut (.i_clk(clk), .i_resetn(resetn), .i_valid(valid), .i_op(op),
        .i_rs(rs), .i_rt(rt), .i_shamt(shamt), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
        .o_hi(hi), .o_lo(lo), .o_ext(ext));
    ace_core_model core (.i_clk(clk), .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_valid(valid),
        .o_op(op), .o_rs(rs), .o_rt(rt), .o_shamt(shamt), .o_wb(wb));

    // ================================================================
    // Reference arithmetic; the carry-less product is worked out bit by bit.
    function automatic logic [63:0] clmul(input logic [31:0] a, input logic [31:0] b);
        logic [63:0] p = 64'h0;
        for (int i = 0; i < 32; i++) begin
            if (b[i]) p = p ^ (64'(a) << i);
        end
        return p;
    endfunction

    task automatic predict(input ace_op_t o, input logic [31:0] a, input logic [31:0] b,
                           input logic [4:0] s);
        logic [EW+63:0] acc = {e_ext, e_hi, e_lo};
        logic [63:0]    rr = {a, a} >> (o == ACE_OP_ROT_IMM ? s : b[4:0]);
        // Sign-extend before multiplying so the full 64-bit signed product is kept.
        logic signed [63:0] sp = $signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b});
        e_rdv = 1'b0;
        case (o)
            ACE_OP_UMUL:    acc = {EW'(0), 64'(a) * 64'(b)};
            ACE_OP_UMAC:    acc = acc + (EW+64)'(64'(a) * 64'(b));
            ACE_OP_SMUL:    acc = {EW'(0), sp};
            ACE_OP_SMAC:    acc = acc + (EW+64)'(sp);
            ACE_OP_SDIV:    acc = {EW'(0), 32'($signed(a) % $signed(b)),
                                   32'($signed(a) / $signed(b))};
            ACE_OP_UDIV:    acc = (b == 0) ? {EW'(0), a, 32'hffffffff}
                                           : {EW'(0), a % b, a / b};
            ACE_OP_SHR_OUT: acc = {EW'(0), 32'(e_ext), e_hi};
            ACE_OP_SHL_IN:  acc = {e_hi[EW-1:0], e_lo, a};
            ACE_OP_PMAC:    acc = {e_ext, {e_hi, e_lo} ^ clmul(a, b)};
            ACE_OP_PMUL:    acc = {e_ext, clmul(a, b)};
            ACE_OP_SHUF: begin
                acc = acc << 6;
                for (int k = 0; k < 6; k++) acc[k] = a[b[5*k +: 5]];
            end
            default: ;
        endcase
        if (o inside {ACE_OP_SHR_OUT, ACE_OP_ROT_IMM, ACE_OP_ROT_VAR}) begin
            e_rdv = 1'b1;
            e_rd = (o == ACE_OP_SHR_OUT) ? e_lo : rr[31:0];
        end
        {e_ext, e_hi, e_lo} = acc;
    endtask

    // ================================================================
    // Comparison, one step, and the closing report.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_all();
        chk("hi", e_hi, hi);
        chk("lo", e_lo, lo);
        chk("ext", 32'(e_ext), 32'(ext));
        chk("rd_valid", 32'(e_rdv), 32'(rd_valid));
        chk("rd_data", e_rd, rd_data);
    endtask

    task automatic step(input ace_op_t o, input logic [31:0] a, input logic [31:0] b,
                        input logic [4:0] s);
        predict(o, a, b, s);
        core.issue(o, a, b, s, 1'b1);
        check_all();
    endtask

    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // A hang is cut short after a bounded number of cycles.
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        complete_run();
    end

    initial begin
        {e_ext, e_hi, e_lo, e_rd, e_rdv} = '0;
        repeat (3) @(negedge clk);
        check_all(); // Outputs are cleared while reset is held.
        resetn = 1'b1;
        for (int i = 0; i < ROWS; i++) begin
            step(rows[i].op, rows[i].rs, rows[i].rt, rows[i].sh);
        end
        $display("table of %0d rows done", ROWS);
        // Requests without the strobe, and the empty code, leave everything alone.
        core.issue(ACE_OP_UMUL, 32'hffffffff, 32'hffffffff, 5'h00, 1'b0);
        check_all();
        step(ACE_OP_NONE, 32'hffffffff, 32'hffffffff, 5'h00);
        chk("wb", 32'h81234567, wb);
        $display("ignored requests done");
        // Reset in mid-run, then back-to-back shifts from the first edge.
        resetn = 1'b0;
        #1;
        {e_ext, e_hi, e_lo, e_rd, e_rdv} = '0;
        check_all();
        @(negedge clk);
        resetn = 1'b1;
        step(ACE_OP_SHL_IN, 32'hcafe0001, 32'h0, 5'h00);
        step(ACE_OP_SHR_OUT, 32'h0, 32'h0, 5'h00);
        core.idle();
        e_rdv = 1'b0;
        check_all();
        $display("reset and back-to-back done");
        complete_run();
    end
endmodule
